// ==== rtl/gips_defines.vh ====
// Constants for the pin interrupt and pin state block.
// Assumes a 32-bit AXI4-Lite register bus and a 20 MHz system clock.
`ifndef GIPS_DEFINES_VH
`define GIPS_DEFINES_VH

`define GIPS_NPINS 26

// Register byte offsets
`define GIPS_OFS_DATA 12'h000
`define GIPS_OFS_OEN 12'h004
`define GIPS_OFS_PE 12'h008
`define GIPS_OFS_DS 12'h00C
`define GIPS_OFS_SENSE 12'h010
`define GIPS_OFS_BOTH 12'h014
`define GIPS_OFS_POL 12'h018
`define GIPS_OFS_MASK 12'h01C
`define GIPS_OFS_RAW 12'h020
`define GIPS_OFS_MSK_ST 12'h024
`define GIPS_OFS_CLEAR 12'h028
`define GIPS_OFS_ALT 12'h02C
`define GIPS_OFS_LP_PULL 12'h030
`define GIPS_OFS_STATUS 12'h034

// Reset values
`define GIPS_RST_ZERO 26'h0000000
`define GIPS_RST_PE 26'h3FFFFFF
`define GIPS_RST_ALT 26'h0000600
`define GIPS_RST_LP_PULL 26'h0000E00

// Per-pin classes
`define GIPS_PULLUP_PINS 26'h0000E00
`define GIPS_PULLDN_PINS 26'h3FFC1FF
`define GIPS_INPUT_ONLY_PINS 26'h0003000
`define GIPS_LP_KEEP_PINS 26'h0000E00

// Bus responses
`define GIPS_RESP_OKAY 2'b00
`define GIPS_RESP_SLVERR 2'b10

// Analog test pulse on pin 14
`define GIPS_ATP_TIME_NS 75000
`define GIPS_CLK_PERIOD_NS 50
`define GIPS_ATP_CYCLES (`GIPS_ATP_TIME_NS / `GIPS_CLK_PERIOD_NS)
`define GIPS_ATP_CNT_W 11

// Status register bit positions
`define GIPS_ST_LOWPOWER 0
`define GIPS_ST_ATP_DONE 1

`endif

// ==== rtl/gips_irq_cell.v ====
// Per-pin trigger detection and sticky raw interrupt status.
// Assumes pin samples are already synchronised to the system clock.
`timescale 1ns/100ps
module gips_irq_cell #(
	parameter WIDTH = 26
) (
	input wire clk,
	input wire rst,
	input wire [WIDTH-1:0] smp,
	input wire [WIDTH-1:0] enable,
	input wire [WIDTH-1:0] sense,
	input wire [WIDTH-1:0] both,
	input wire [WIDTH-1:0] pol,
	input wire [WIDTH-1:0] clr,
	output reg [WIDTH-1:0] raw_ff
);
	reg [WIDTH-1:0] prev_ff;
	wire [WIDTH-1:0] rise;
	wire [WIDTH-1:0] fall;
	wire [WIDTH-1:0] edge_hit;
	wire [WIDTH-1:0] lvl_hit;
	wire [WIDTH-1:0] hit;
	wire [WIDTH-1:0] nxt_raw;

	// Edges from successive synchronised samples
	assign rise = smp & ~prev_ff;
	assign fall = ~smp & prev_ff;
	// Trigger selection
	assign edge_hit = (both & (rise | fall)) | (~both & pol & rise) | (~both & ~pol & fall);
	assign lvl_hit = (pol & smp) | (~pol & ~smp);
	assign hit = enable & ((sense & lvl_hit) | (~sense & edge_hit));
	// Set wins over a simultaneous clear
	assign nxt_raw = hit | (raw_ff & ~clr);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_ff <= {WIDTH{1'b0}};
			raw_ff <= {WIDTH{1'b0}};
		end else begin
			prev_ff <= smp;
			raw_ff <= nxt_raw;
		end
	end
endmodule

// ==== rtl/gips_top.v ====
// Pin interrupt detection, pin reset state and low-power pin state, AXI4-Lite slave.
// Assumes pads resolve IO_OUT/IO_OE/IO_PU/IO_PD; LOW_POWER comes from MCLK logic.
`timescale 1ns/100ps
`include "gips_defines.vh"
module gips_top #(
	parameter NPINS = `GIPS_NPINS,
	parameter ADDR_W = 12,
	parameter ATP_BONDED = 1'b1
) (
	input wire MCLK,
	input wire SYS_RST,
	input wire [ADDR_W-1:0] AWADDR,
	input wire AWVALID,
	output wire AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output wire WREADY,
	output reg [1:0] BRESP,
	output reg BVALID,
	input wire BREADY,
	input wire [ADDR_W-1:0] ARADDR,
	input wire ARVALID,
	output wire ARREADY,
	output reg [31:0] RDATA,
	output reg [1:0] RRESP,
	output reg RVALID,
	input wire RREADY,
	input wire [NPINS-1:0] IO_IN,
	output reg [NPINS-1:0] IO_OUT,
	output reg [NPINS-1:0] IO_OE,
	output reg [NPINS-1:0] IO_PU,
	output reg [NPINS-1:0] IO_PD,
	output wire [NPINS-1:0] IO_DS,
	input wire [NPINS-1:0] ALT_OUT,
	input wire [NPINS-1:0] ALT_OE,
	input wire LOW_POWER,
	output reg IRQ,
	output reg ANALOG_TEST_LINE
);
	reg [NPINS-1:0] data_ff;
	reg [NPINS-1:0] oen_ff;
	reg [NPINS-1:0] pe_ff;
	reg [NPINS-1:0] ds_ff;
	reg [NPINS-1:0] sense_ff;
	reg [NPINS-1:0] both_ff;
	reg [NPINS-1:0] pol_ff;
	reg [NPINS-1:0] mask_ff;
	reg [NPINS-1:0] alt_ff;
	reg [NPINS-1:0] lp_pull_ff;
	reg [NPINS-1:0] in_s1_ff;
	reg [NPINS-1:0] in_s2_ff;
	reg aw_hold_ff;
	reg [ADDR_W-1:0] aw_addr_ff;
	reg w_hold_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	reg [`GIPS_ATP_CNT_W-1:0] atp_cnt_ff;
	reg atp_done_ff;
	wire [NPINS-1:0] raw_st;
	wire [NPINS-1:0] masked_st;
	wire [NPINS-1:0] gpio_mode;
	wire [NPINS-1:0] clr_vec;
	wire [NPINS-1:0] wr_bits;
	wire [31:0] wr_mask;
	wire do_write;
	reg [31:0] rd_word;
	reg rd_ok;
	reg wr_ok;
	reg [NPINS-1:0] nxt_oe;
	reg [NPINS-1:0] nxt_out;
	reg [NPINS-1:0] nxt_pu;
	reg [NPINS-1:0] nxt_pd;

	// Byte lane mask from write strobes
	function [31:0] gips_lanes;
		input [3:0] strb;
		begin
			gips_lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		end
	endfunction

	// Merge a write into a stored register under byte enables
	function [NPINS-1:0] gips_merge;
		input [NPINS-1:0] old;
		input [NPINS-1:0] val;
		input [NPINS-1:0] msk;
		begin
			gips_merge = (old & ~msk) | (val & msk);
		end
	endfunction

	// Write channel: address and data taken in either order
	assign AWREADY = ~aw_hold_ff & ~BVALID;
	assign WREADY = ~w_hold_ff & ~BVALID;
	assign do_write = aw_hold_ff & w_hold_ff & ~BVALID;
	assign wr_mask = gips_lanes(w_strb_ff);
	assign wr_bits = w_data_ff[NPINS-1:0] & wr_mask[NPINS-1:0];

	// Clear pulses only from ones written to the clear register
	assign clr_vec = (do_write && {aw_addr_ff[ADDR_W-1:2], 2'b00} == `GIPS_OFS_CLEAR) ?
		wr_bits : {NPINS{1'b0}};

	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			aw_hold_ff <= 1'b0;
			aw_addr_ff <= {ADDR_W{1'b0}};
			w_hold_ff <= 1'b0;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= `GIPS_RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_hold_ff <= 1'b1;
				aw_addr_ff <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_hold_ff <= 1'b1;
				w_data_ff <= WDATA;
				w_strb_ff <= WSTRB;
			end
			if (do_write) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_ok ? `GIPS_RESP_OKAY : `GIPS_RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	// Write decode
	always @* begin
		case ({aw_addr_ff[ADDR_W-1:2], 2'b00})
			`GIPS_OFS_DATA, `GIPS_OFS_OEN, `GIPS_OFS_PE, `GIPS_OFS_DS,
			`GIPS_OFS_SENSE, `GIPS_OFS_BOTH, `GIPS_OFS_POL, `GIPS_OFS_MASK,
			`GIPS_OFS_RAW, `GIPS_OFS_MSK_ST, `GIPS_OFS_CLEAR, `GIPS_OFS_ALT,
			`GIPS_OFS_LP_PULL, `GIPS_OFS_STATUS: begin
				wr_ok = 1'b1;
			end
			default: begin
				wr_ok = 1'b0;
			end
		endcase
	end

	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			data_ff <= `GIPS_RST_ZERO;
			oen_ff <= `GIPS_RST_ZERO;
			pe_ff <= `GIPS_RST_PE;
			ds_ff <= `GIPS_RST_ZERO;
			sense_ff <= `GIPS_RST_ZERO;
			both_ff <= `GIPS_RST_ZERO;
			pol_ff <= `GIPS_RST_ZERO;
			mask_ff <= `GIPS_RST_ZERO;
			alt_ff <= `GIPS_RST_ALT;
			lp_pull_ff <= `GIPS_RST_LP_PULL;
		end else if (do_write) begin
			case ({aw_addr_ff[ADDR_W-1:2], 2'b00})
				`GIPS_OFS_DATA: begin
					data_ff <= gips_merge(data_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_OEN: begin
					oen_ff <= gips_merge(oen_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_PE: begin
					pe_ff <= gips_merge(pe_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_DS: begin
					ds_ff <= gips_merge(ds_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_SENSE: begin
					sense_ff <= gips_merge(sense_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_BOTH: begin
					both_ff <= gips_merge(both_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_POL: begin
					pol_ff <= gips_merge(pol_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_MASK, `GIPS_OFS_MSK_ST: begin
					// Mask and masked status addresses both write the mask
					mask_ff <= gips_merge(mask_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_ALT: begin
					alt_ff <= gips_merge(alt_ff, w_data_ff[NPINS-1:0], wr_mask[NPINS-1:0]);
				end
				`GIPS_OFS_LP_PULL: begin
					lp_pull_ff <= gips_merge(lp_pull_ff, w_data_ff[NPINS-1:0],
						wr_mask[NPINS-1:0] & `GIPS_LP_KEEP_PINS);
				end
				default: begin
					lp_pull_ff <= lp_pull_ff;
				end
			endcase
		end
	end

	// Read channel
	assign ARREADY = ~RVALID;

	always @* begin
		rd_word = 32'h00000000;
		rd_ok = 1'b1;
		case ({ARADDR[ADDR_W-1:2], 2'b00})
			`GIPS_OFS_DATA: begin
				rd_word[NPINS-1:0] = in_s2_ff;
			end
			`GIPS_OFS_OEN: begin
				rd_word[NPINS-1:0] = oen_ff;
			end
			`GIPS_OFS_PE: begin
				rd_word[NPINS-1:0] = pe_ff;
			end
			`GIPS_OFS_DS: begin
				rd_word[NPINS-1:0] = ds_ff;
			end
			`GIPS_OFS_SENSE: begin
				rd_word[NPINS-1:0] = sense_ff;
			end
			`GIPS_OFS_BOTH: begin
				rd_word[NPINS-1:0] = both_ff;
			end
			`GIPS_OFS_POL: begin
				rd_word[NPINS-1:0] = pol_ff;
			end
			`GIPS_OFS_MASK: begin
				rd_word[NPINS-1:0] = mask_ff;
			end
			`GIPS_OFS_RAW: begin
				rd_word[NPINS-1:0] = raw_st;
			end
			`GIPS_OFS_MSK_ST: begin
				rd_word[NPINS-1:0] = masked_st;
			end
			`GIPS_OFS_CLEAR: begin
				rd_word = 32'h00000000;
			end
			`GIPS_OFS_ALT: begin
				rd_word[NPINS-1:0] = alt_ff;
			end
			`GIPS_OFS_LP_PULL: begin
				rd_word[NPINS-1:0] = lp_pull_ff;
			end
			`GIPS_OFS_STATUS: begin
				rd_word[`GIPS_ST_LOWPOWER] = LOW_POWER;
				rd_word[`GIPS_ST_ATP_DONE] = atp_done_ff;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `GIPS_RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			RVALID <= 1'b1;
			RDATA <= rd_word;
			RRESP <= rd_ok ? `GIPS_RESP_OKAY : `GIPS_RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end
	end

	// Pin input synchroniser
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			in_s1_ff <= {NPINS{1'b0}};
			in_s2_ff <= {NPINS{1'b0}};
		end else begin
			in_s1_ff <= IO_IN;
			in_s2_ff <= in_s1_ff;
		end
	end

	// Pins 9-11 are forced to general purpose in low power
	assign gpio_mode = LOW_POWER ? (~alt_ff | `GIPS_LP_KEEP_PINS) : ~alt_ff;

	gips_irq_cell #(
		.WIDTH(NPINS)
	) u_irq (
		.clk(MCLK),
		.rst(SYS_RST),
		.smp(in_s2_ff),
		.enable(gpio_mode),
		.sense(sense_ff),
		.both(both_ff),
		.pol(pol_ff),
		.clr(clr_vec),
		.raw_ff(raw_st)
	);

	assign masked_st = raw_st & mask_ff;

	// Combined interrupt line
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |masked_st;
		end
	end

	// Pad state selection
	always @* begin
		if (LOW_POWER) begin
			nxt_oe = oen_ff & `GIPS_LP_KEEP_PINS;
			nxt_out = data_ff & `GIPS_LP_KEEP_PINS;
			nxt_pu = lp_pull_ff & `GIPS_PULLUP_PINS;
			nxt_pd = {NPINS{1'b0}};
		end else begin
			nxt_oe = (~alt_ff & oen_ff) | (alt_ff & ALT_OE);
			nxt_out = (~alt_ff & data_ff) | (alt_ff & ALT_OUT);
			nxt_pu = pe_ff & `GIPS_PULLUP_PINS;
			nxt_pd = pe_ff & `GIPS_PULLDN_PINS;
		end
		nxt_oe = nxt_oe & ~`GIPS_INPUT_ONLY_PINS;
		nxt_pu = nxt_pu & ~`GIPS_INPUT_ONLY_PINS;
		nxt_pd = nxt_pd & ~`GIPS_INPUT_ONLY_PINS;
	end

	// Pads float under reset
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			IO_OE <= {NPINS{1'b0}};
			IO_OUT <= {NPINS{1'b0}};
			IO_PU <= {NPINS{1'b0}};
			IO_PD <= {NPINS{1'b0}};
		end else begin
			IO_OE <= nxt_oe;
			IO_OUT <= nxt_out;
			IO_PU <= nxt_pu;
			IO_PD <= nxt_pd;
		end
	end

	assign IO_DS = ds_ff;

	// Test line pulse after reset release
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			atp_cnt_ff <= {`GIPS_ATP_CNT_W{1'b0}};
			atp_done_ff <= 1'b0;
			ANALOG_TEST_LINE <= 1'b0;
		end else begin
			ANALOG_TEST_LINE <= ATP_BONDED & ~atp_done_ff;
			if (!atp_done_ff) begin
				atp_cnt_ff <= atp_cnt_ff + {{(`GIPS_ATP_CNT_W-1){1'b0}}, 1'b1};
				if (atp_cnt_ff == `GIPS_ATP_CYCLES - 1) begin
					atp_done_ff <= 1'b1;
				end
			end
		end
	end
endmodule

// ==== tb/gips_pin_src.sv ====
// Pin source model: external signals on the IO pins.
// Assumes the caller asks for changes from the MCLK domain.
`timescale 1ns/100ps
module gips_pin_src (
	output reg [25:0] pins,
	input wire mclk
);
	initial pins = 26'h0000000;
	// Each pin changes alone or with others, then holds
	task drive(input [25:0] v, input integer hold);
		begin
			@(posedge mclk);
			pins <= v;
			repeat (hold) @(posedge mclk);
		end
	endtask
endmodule

// ==== tb/gips_top_monitor.sv ====
// Checker for pin states, test pulse and bus answers.
// Assumes it is bound to gips_top and sees only its ports.
`timescale 1ns/100ps
module gips_top_monitor #(
	parameter NPINS = 26
) (
	input wire MCLK,
	input wire SYS_RST,
	input wire ARVALID,
	input wire ARREADY,
	input wire RVALID,
	input wire RREADY,
	input wire BVALID,
	input wire BREADY,
	input wire [NPINS-1:0] IO_OE,
	input wire [NPINS-1:0] IO_PU,
	input wire [NPINS-1:0] IO_PD,
	input wire LOW_POWER,
	input wire ANALOG_TEST_LINE
);
	reg [10:0] plen_ff;
	// Counts the cycles of the test pulse
	always @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			plen_ff <= 11'h000;
		end else if (ANALOG_TEST_LINE) begin
			plen_ff <= plen_ff + 11'h001;
		end
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (SYS_RST);
	sequence ar_take;
		ARVALID && ARREADY;
	endsequence
	sequence r_done;
		RVALID && RREADY;
	endsequence
	sequence b_done;
		BVALID && BREADY;
	endsequence
	rst_hiz_a: assert property (disable iff (1'b0)
		SYS_RST |-> (IO_OE | IO_PU | IO_PD) == 26'h0000000)
		else $error("pins not floating in reset");
	input_only_a: assert property (
		((IO_OE | IO_PU | IO_PD) & 26'h0003000) == 26'h0000000)
		else $error("input-only pins driven or pulled");
	lowpower_hiz_a: assert property ($past(LOW_POWER) |->
		((IO_OE | IO_PU | IO_PD) & 26'h3FFF1FF) == 26'h0000000)
		else $error("pins not floating in low power");
	reset_pulls_a: assert property ($fell(SYS_RST) && !LOW_POWER |=>
		IO_PD == 26'h3FFC1FF && IO_PU == 26'h0000E00 && ANALOG_TEST_LINE)
		else $error("pin state after reset wrong");
	pulse_len_a: assert property ($fell(ANALOG_TEST_LINE) |-> plen_ff == 11'h5DC)
		else $error("test pulse length wrong");
	read_answer_a: assert property (ar_take |=> RVALID)
		else $error("read answer late");
	read_release_a: assert property (r_done |=> !RVALID)
		else $error("read valid held after accept");
	write_release_a: assert property (b_done |=> !BVALID)
		else $error("write response held after accept");
endmodule
bind gips_top gips_top_monitor #(.NPINS(NPINS)) gips_top_monitor_inst (
	.MCLK(MCLK), .SYS_RST(SYS_RST), .ARVALID(ARVALID), .ARREADY(ARREADY),
	.RVALID(RVALID), .RREADY(RREADY), .BVALID(BVALID), .BREADY(BREADY),
	.IO_OE(IO_OE), .IO_PU(IO_PU), .IO_PD(IO_PD), .LOW_POWER(LOW_POWER),
	.ANALOG_TEST_LINE(ANALOG_TEST_LINE)
);

// ==== tb/gips_top_tb_top.sv ====
// Testbench: random pin events against a behavioural interrupt model.
// Assumes gips_top with default parameters and the pin source model.
`timescale 1ns/100ps
module gips_top_tb_top;
	localparam integer M = 32'h03FFFFFF;
	reg MCLK = 1'b0;
	reg SYS_RST = 1'b0;
	reg [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
	reg [31:0] WDATA = 32'h00000000;
	reg AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	reg ARVALID = 1'b0, RREADY = 1'b0, LOW_POWER = 1'b0;
	wire AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, ANALOG_TEST_LINE;
	wire [1:0] BRESP, RRESP;
	wire [31:0] RDATA;
	wire [25:0] IO_IN, IO_OE, IO_PU, IO_OUT, IO_PD, IO_DS;
	integer fails = 0;
	integer total_checks = 0;
	integer seed = 25372;
	integer plen = 0;
	integer i, raw, msk, sns, bth, pol, cur, nv, clr;
	gips_top gips_top_inst (
		.MCLK(MCLK), .SYS_RST(SYS_RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
		.ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
		.RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IO_IN(IO_IN),
		.IO_OUT(IO_OUT), .IO_OE(IO_OE), .IO_PU(IO_PU), .IO_PD(IO_PD), .IO_DS(IO_DS),
		.ALT_OUT(26'h0000000), .ALT_OE(26'h0000000), .LOW_POWER(LOW_POWER),
		.IRQ(IRQ), .ANALOG_TEST_LINE(ANALOG_TEST_LINE)
	);
	gips_pin_src gips_pin_src_inst (.pins(IO_IN), .mclk(MCLK));
	always #25 MCLK = ~MCLK;
	always @(posedge MCLK) if (ANALOG_TEST_LINE === 1'b1) plen = plen + 1;
	task stop_test;
		begin
			$display("Checks %0d mismatches %0d", total_checks, fails);
			if (fails == 0 && total_checks > 0) begin
				$display("All tests passed");
			end else begin
				$display("Some tests failed");
			end
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("Error %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task tmo(input integer n);
		if (n >= 50) begin
			chk("answer", 1, 0);
			stop_test;
		end
	endtask
	task wr(input [11:0] a, input [31:0] d, input [1:0] er);
		integer n;
		begin
			@(posedge MCLK);
			AWADDR <= a;
			WDATA <= d;
			AWVALID <= 1'b1;
			WVALID <= 1'b1;
			BREADY <= 1'b1;
			n = 0;
			do begin
				@(posedge MCLK);
				n = n + 1;
				if (AWREADY) AWVALID <= 1'b0;
				if (WREADY) WVALID <= 1'b0;
			end while (!BVALID && n < 50);
			BREADY <= 1'b0;
			tmo(n);
			chk("bresp", er, BRESP);
		end
	endtask
	task rdc(input [11:0] a, input [31:0] e, input [1:0] er);
		integer n;
		begin
			@(posedge MCLK);
			ARADDR <= a;
			ARVALID <= 1'b1;
			RREADY <= 1'b1;
			n = 0;
			do begin
				@(posedge MCLK);
				n = n + 1;
				if (ARREADY) ARVALID <= 1'b0;
			end while (!RVALID && n < 50);
			RREADY <= 1'b0;
			tmo(n);
			chk("rdata", e, RDATA);
			chk("rresp", er, RRESP);
		end
	endtask
	initial begin
		SYS_RST <= 1'b1;
		repeat (10) @(posedge MCLK);
		SYS_RST <= 1'b0;
		rdc(12'h008, M, 2'b00);
		rdc(12'h02C, 32'h00000600, 2'b00);
		rdc(12'h028, 0, 2'b00);
		wr(12'h02C, 0, 2'b00);
		wr(12'h040, M, 2'b10);
		rdc(12'h040, 0, 2'b10);
		$display("register test done");
		cur = 0;
		for (i = 0; i < 30; i = i + 1) begin
			sns = $random(seed) & M;
			bth = $random(seed) & M;
			pol = $random(seed) & M;
			msk = $random(seed) & M;
			wr(12'h010, 0, 2'b00);
			wr(12'h014, bth, 2'b00);
			wr(12'h018, pol, 2'b00);
			wr(12'h010, sns, 2'b00);
			wr(12'h028, M, 2'b00);
			raw = sns & ~(pol ^ cur);
			wr(i[0] ? 12'h024 : 12'h01C, msk, 2'b00);
			nv = $random(seed) & M;
			gips_pin_src_inst.drive(nv[25:0], 4);
			raw = raw | (sns & ~(pol ^ nv)) | (~sns & (cur ^ nv) & (bth | ~(pol ^ nv)));
			cur = nv;
			rdc(12'h020, raw, 2'b00);
			rdc(12'h000, cur, 2'b00);
			rdc(12'h024, raw & msk, 2'b00);
			chk("irq", |(raw & msk), IRQ);
			clr = $random(seed);
			wr(12'h028, clr, 2'b00);
			raw = raw & ~clr | sns & ~(pol ^ cur);
			wr(12'h020, M, 2'b00);
			rdc(12'h020, raw, 2'b00);
		end
		$display("interrupt test done");
		wr(12'h004, M, 2'b00);
		wr(12'h000, 32'h02AAAAAA, 2'b00);
		wr(12'h00C, 32'h01555555, 2'b00);
		repeat (2) @(posedge MCLK);
		chk("oe", 32'h03FFCFFF, IO_OE);
		chk("out", 32'h02AAAAAA, IO_OUT);
		chk("ds", 32'h01555555, IO_DS);
		LOW_POWER <= 1'b1;
		repeat (3) @(posedge MCLK);
		chk("oe_lp", 32'h00000E00, IO_OE);
		chk("pu_lp", 32'h00000E00, IO_PU);
		chk("out_lp", 32'h00000A00, IO_OUT);
		chk("pd_lp", 32'h00000000, IO_PD);
		LOW_POWER <= 1'b0;
		repeat (1600) @(posedge MCLK);
		chk("pulse", 1500, plen);
		rdc(12'h034, 32'h00000002, 2'b00);
		$display("low power test done");
		stop_test;
	end
endmodule
